// *** pas_pkg.sv ***
package pas_pkg;
  // Register map and shutdown control register layout
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STAT  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_CLR   = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
  localparam logic [3:0] ADDR_PWM_DRIVE = 4'h5;
  localparam int CTRL_SRC_LO   = 0;
  localparam int CTRL_SRC_HI   = 2;
  localparam int CTRL_AC_LO    = 3;
  localparam int CTRL_AC_HI    = 4;
  localparam int CTRL_BD_LO    = 5;
  localparam int CTRL_BD_HI    = 6;
  localparam int CTRL_ESTAT    = 7;
  localparam int CTRL_RESTART  = 8;
  localparam int SRC_FAULT_BIT = 0;
  localparam int SRC_CMP_BIT   = 1;
  localparam int IRQ_SHUTDOWN  = 0;
  localparam int IRQ_RESTART   = 1;
  localparam int IRQ_W         = 2;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  typedef enum logic [1:0] {
    PAS_SS_LOW  = 2'b00,
    PAS_SS_HIGH = 2'b01,
    PAS_SS_HIZ  = 2'b10
  } pas_ss_t;
  typedef enum logic [1:0] {
    PAS_RUN  = 2'b00,
    PAS_SHUT = 2'b01,
    PAS_WAIT = 2'b11
  } pas_state_t;
endpackage

// *** pas_sync.sv ***
`timescale 1ns/1ns
// Three-stage synchroniser; a change counts once stages two and three agree
module pas_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic [2:0] sync_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync_reg <= {3{RESET_VAL}};
      q_o      <= RESET_VAL;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], d_i};
      if (sync_reg[2] == sync_reg[1])
      begin
        q_o <= sync_reg[2];
      end
    end
  end
endmodule // pas_sync

// *** pas_shutdown.sv ***
`timescale 1ns/1ns
// Function
// RQ1: Three-bit source select picks which hardware events may shut down.
// RQ2: Selected fault input low is a shutdown event.
// RQ3: Selected comparator output high is a shutdown event.
// RQ4: Status bit reads 0 while running, 1 while shut down.
// RQ5: Shutdown sets status; stays set until firmware or auto-restart clears.
// RQ6: Outputs forced to safe levels combinationally, no clock edge needed.
// RQ7: Outputs handled as pairs A/C and B/D, each with own state field.
// RQ8: Each pair state: drive high, drive low, or high impedance.
// RQ9: Shutdown is level based; persists while fault level present.
// RQ10: Firmware writes to status bit ignored while hardware fault active.
// RQ11: After restart, outputs resume only at the next PWM period start.
// RQ12: Firmware writing 1 to status forces a software shutdown.
// RQ13: Auto-restart follows hardware faults only; clears forced shutdown at once.
// RQ14: Auto-restart clears status when fault leaves; else firmware must clear.
// RQ15: Hardware fault in same cycle as firmware clear keeps shutdown.
module pas_shutdown (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        fault_input_n_i,
  input  wire logic        first_comparator_output_i,
  input  wire logic        period_start_i,
  input  wire logic [3:0]  pwm_raw_i,
  output logic             pwm_out_a_o,
  output logic             pwm_out_a_oe_o,
  output logic             pwm_out_b_o,
  output logic             pwm_out_b_oe_o,
  output logic             pwm_out_c_o,
  output logic             pwm_out_c_oe_o,
  output logic             pwm_out_d_o,
  output logic             pwm_out_d_oe_o,
  output logic             irq_o
);
  logic [8:0]            shutdown_control_reg;
  logic [3:0]            pwm_drive_en_reg;
  logic [pas_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [pas_pkg::IRQ_W-1:0] irq_en_reg;
  logic                  shutdown_event_status;
  logic                  wait_reg;
  pas_pkg::pas_state_t   state;
  logic                  fault_sync;
  logic                  cmp_sync;
  logic                  hw_fault;
  logic                  hw_fault_raw;
  logic                  shut_now;
  logic                  bus_req;
  logic                  wr_ctrl;
  logic                  wr_estat;
  logic                  wr_estat_val;
  logic                  status_next;
  logic                  restart_evt;
  logic                  shutdown_evt;
  logic [3:0]            reg_idx;
  logic [31:0]           rd_next;
  logic                  valid_adr;
  logic [2:0]            src_sel;
  logic [1:0]            ss_ac;
  logic [1:0]            ss_bd;
  logic                  auto_restart_enable;
  logic [3:0]            pin_val;
  logic [3:0]            pin_oe;

  // The fault pin is low-active, so it idles high out of reset
  pas_sync #(.RESET_VAL(1'b1)) u_sync_fault (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (fault_input_n_i),
    .q_o   (fault_sync)
  );
  pas_sync #(.RESET_VAL(1'b0)) u_sync_cmp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (first_comparator_output_i),
    .q_o   (cmp_sync)
  );

  assign src_sel = shutdown_control_reg[pas_pkg::CTRL_SRC_HI:pas_pkg::CTRL_SRC_LO]; // see RQ1
  assign ss_ac   = shutdown_control_reg[pas_pkg::CTRL_AC_HI:pas_pkg::CTRL_AC_LO];
  assign ss_bd   = shutdown_control_reg[pas_pkg::CTRL_BD_HI:pas_pkg::CTRL_BD_LO];
  assign auto_restart_enable = shutdown_control_reg[pas_pkg::CTRL_RESTART];

  // Synchronised view drives the sticky status
  assign hw_fault = (src_sel[pas_pkg::SRC_FAULT_BIT] & ~fault_sync)     // see RQ2
                  | (src_sel[pas_pkg::SRC_CMP_BIT] & cmp_sync);          // see RQ3
  // Raw pin view forces outputs with no clock; glitches may briefly shut down, which is safe
  assign hw_fault_raw = (src_sel[pas_pkg::SRC_FAULT_BIT] & ~fault_input_n_i)
                      | (src_sel[pas_pkg::SRC_CMP_BIT] & first_comparator_output_i); // see RQ6

  // Wishbone decode: word addresses in the low bits above the byte lane
  assign reg_idx   = wb_adr_i[5:2];
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign valid_adr = reg_idx <= pas_pkg::ADDR_PWM_DRIVE;
  assign wr_ctrl   = bus_req & valid_adr & wb_we_i & (reg_idx == pas_pkg::ADDR_CTRL);
  assign wr_estat  = wr_ctrl & wb_sel_i[0];
  assign wr_estat_val = wb_dat_i[pas_pkg::CTRL_ESTAT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req & valid_adr;
      wb_err_o <= bus_req & ~valid_adr;
    end
  end

  always_comb
  begin
    rd_next = 32'h0000_0000;
    unique case (reg_idx)
      pas_pkg::ADDR_CTRL:
      begin
        rd_next[8:0] = shutdown_control_reg;
        rd_next[pas_pkg::CTRL_ESTAT] = shutdown_event_status; // see RQ4
      end
      pas_pkg::ADDR_STATUS:
      begin
        rd_next[0] = hw_fault;
        rd_next[1] = wait_reg;
      end
      pas_pkg::ADDR_IRQ_STAT:  rd_next[pas_pkg::IRQ_W-1:0] = irq_stat_reg;
      pas_pkg::ADDR_IRQ_EN:    rd_next[pas_pkg::IRQ_W-1:0] = irq_en_reg;
      pas_pkg::ADDR_PWM_DRIVE: rd_next[3:0] = pwm_drive_en_reg;
      default:                 rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (bus_req & ~wb_we_i)
    begin
      wb_dat_o <= rd_next;
    end
  end

  // Control fields other than the status bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shutdown_control_reg <= pas_pkg::CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      if (wb_sel_i[0])
      begin
        shutdown_control_reg[pas_pkg::CTRL_BD_HI:pas_pkg::CTRL_SRC_LO] <= wb_dat_i[pas_pkg::CTRL_BD_HI:pas_pkg::CTRL_SRC_LO];
      end
      if (wb_sel_i[1])
      begin
        shutdown_control_reg[pas_pkg::CTRL_RESTART] <= wb_dat_i[pas_pkg::CTRL_RESTART];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_drive_en_reg <= 4'h0;
    end
    else if (bus_req & wb_we_i & wb_sel_i[0] & (reg_idx == pas_pkg::ADDR_PWM_DRIVE))
    begin
      pwm_drive_en_reg <= wb_dat_i[3:0];
    end
  end

  // Sticky shutdown status
  always_comb
  begin
    status_next = shutdown_event_status;
    if (wr_estat & ~hw_fault)                                  // see RQ10
    begin
      status_next = wr_estat_val;                              // see RQ12
    end
    if (auto_restart_enable & ~hw_fault)
    begin
      status_next = 1'b0;                                      // see RQ13, RQ14
    end
    if (hw_fault)
    begin
      status_next = 1'b1;                                      // see RQ5, RQ9, RQ15
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shutdown_event_status <= 1'b0;
    end
    else
    begin
      shutdown_event_status <= status_next;
    end
  end

  assign shutdown_evt = status_next & ~shutdown_event_status;
  assign restart_evt  = ~status_next & shutdown_event_status;

  // Output hold until the next period start after the status clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= pas_pkg::PAS_RUN;
    end
    else
    begin
      unique case (state)
        pas_pkg::PAS_RUN:
          if (status_next)
          begin
            state <= pas_pkg::PAS_SHUT;
          end
          // Auto-restart wipes a forced status at once, yet the outputs must still pause a period
          else if (wr_estat & wr_estat_val)
          begin
            state <= pas_pkg::PAS_WAIT;                         // see RQ13
          end
        pas_pkg::PAS_SHUT:
          if (~status_next)
          begin
            state <= pas_pkg::PAS_WAIT;
          end
        pas_pkg::PAS_WAIT:
          if (status_next)
          begin
            state <= pas_pkg::PAS_SHUT;
          end
          else if (period_start_i)
          begin
            state <= pas_pkg::PAS_RUN;                         // see RQ11
          end
        default: state <= pas_pkg::PAS_SHUT;
      endcase
    end
  end
  assign wait_reg = (state == pas_pkg::PAS_WAIT);

  // Forced state is combinational from the raw fault so no edge is needed
  assign shut_now = hw_fault_raw | (state != pas_pkg::PAS_RUN) | shutdown_event_status; // see RQ6, RQ4

  function automatic logic [1:0] pas_pin(input logic raw, input logic en, input logic sd, input logic [1:0] ss);
    logic [1:0] r;
    r = {en, raw};
    if (sd)
    begin
      unique case (ss)
        pas_pkg::PAS_SS_HIGH: r = {en, 1'b1};                  // see RQ8
        pas_pkg::PAS_SS_LOW:  r = {en, 1'b0};
        default:              r = 2'b00;
      endcase
    end
    return r;
  endfunction

  // Pair A/C uses one field and pair B/D the other
  for (genvar g = 0; g < 4; g++)
  begin : g_pin
    assign {pin_oe[g], pin_val[g]} = pas_pin(pwm_raw_i[g], pwm_drive_en_reg[g], shut_now,
                                             (g % 2 == 0) ? ss_ac : ss_bd); // see RQ7
  end
  assign pwm_out_a_o    = pin_val[0];
  assign pwm_out_a_oe_o = pin_oe[0];
  assign pwm_out_b_o    = pin_val[1];
  assign pwm_out_b_oe_o = pin_oe[1];
  assign pwm_out_c_o    = pin_val[2];
  assign pwm_out_c_oe_o = pin_oe[2];
  assign pwm_out_d_o    = pin_val[3];
  assign pwm_out_d_oe_o = pin_oe[3];

  // Interrupt status: set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg <= '0;
      irq_en_reg   <= '0;
    end
    else
    begin
      if (bus_req & wb_we_i & wb_sel_i[0] & (reg_idx == pas_pkg::ADDR_IRQ_EN))
      begin
        irq_en_reg <= wb_dat_i[pas_pkg::IRQ_W-1:0];
      end
      irq_stat_reg <= (irq_stat_reg
                       & ~((bus_req & wb_we_i & wb_sel_i[0] & (reg_idx == pas_pkg::ADDR_IRQ_CLR))
                           ? wb_dat_i[pas_pkg::IRQ_W-1:0] : {pas_pkg::IRQ_W{1'b0}}))
                      | {restart_evt, shutdown_evt};
    end
  end
  assign irq_o = |(irq_stat_reg & irq_en_reg);

  a_fault_sets_status: assert property (@(posedge clk_i) disable iff (rst_i)
    hw_fault |=> shutdown_event_status) else $error("fault did not set status"); // see RQ5
  a_fault_blocks_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (hw_fault && wr_estat && !wr_estat_val) |=> shutdown_event_status) else $error("clear won over fault"); // see RQ15
  a_sw_force_shut: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_estat && wr_estat_val && !hw_fault && !auto_restart_enable) |=> shutdown_event_status)
    else $error("software force lost"); // see RQ12
  a_auto_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_restart_enable && !hw_fault) |=> !shutdown_event_status) else $error("auto restart did not clear"); // see RQ13
  a_hold_no_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    (shutdown_event_status && !auto_restart_enable && !wr_estat) |=> shutdown_event_status)
    else $error("status dropped without clear"); // see RQ14
  sequence s_cleared;
    $fell(shutdown_event_status);
  endsequence
  a_resume_period: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == pas_pkg::PAS_WAIT && !period_start_i) |=> state != pas_pkg::PAS_RUN)
    else $error("resumed mid period"); // see RQ11
  a_wait_after_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    s_cleared |-> state != pas_pkg::PAS_RUN) else $error("no wait after clear"); // see RQ11
  a_forced_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (hw_fault_raw && ss_ac == pas_pkg::PAS_SS_HIGH && pwm_drive_en_reg[0]) |-> pwm_out_a_o && pwm_out_c_o)
    else $error("pair level wrong"); // see RQ6
  a_hiz_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (shut_now && ss_bd == pas_pkg::PAS_SS_HIZ) |-> !pwm_out_b_oe_o && !pwm_out_d_oe_o)
    else $error("pair not released"); // see RQ8
  a_force_auto_wait: assert property (@(posedge clk_i) disable iff (rst_i) // see RQ13
    (wr_estat && wr_estat_val && auto_restart_enable) |=> state != pas_pkg::PAS_RUN)
    else $error("forced shutdown skipped");
endmodule // pas_shutdown

// *** pas_stage.sv ***
`timescale 1ns/1ns
// Far side: fault sources plus a gate driver whose inputs have pull-downs
module pas_stage (
  input  wire logic       fault_req_i,
  input  wire logic       cmp_req_i,
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_i,
  output logic            fault_input_n_o,
  output logic            cmp_o,
  output logic [3:0]      level_o
);
  assign fault_input_n_o = ~fault_req_i;
  assign cmp_o           = cmp_req_i;
  // A released pin falls to the pull-down, so hi-Z never shows the last level
  assign level_o         = pin_i & oe_i;
endmodule // pas_stage

// *** pas_shutdown_test.sv ***
`timescale 1ns/1ns
module pas_shutdown_test;
  typedef struct {logic [8:0] ctrl; logic [1:0] fc; logic [3:0] oe; logic [3:0] lvl; logic st;} pas_row_t;
  logic        clk, rst, cyc, stb, we, ack, err, pst, freq, creq, flt_n, cmp, irq, e;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  raw, pin, oe, lvl;
  int          err_count, n_tests, i;
  pas_row_t    rows [8];

  pas_shutdown dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .fault_input_n_i(flt_n), .first_comparator_output_i(cmp),
    .period_start_i(pst), .pwm_raw_i(raw), .pwm_out_a_o(pin[0]), .pwm_out_a_oe_o(oe[0]),
    .pwm_out_b_o(pin[1]), .pwm_out_b_oe_o(oe[1]), .pwm_out_c_o(pin[2]), .pwm_out_c_oe_o(oe[2]),
    .pwm_out_d_o(pin[3]), .pwm_out_d_oe_o(oe[3]), .irq_o(irq));

  pas_stage fs (.fault_req_i(freq), .cmp_req_i(creq), .pin_i(pin), .oe_i(oe),
    .fault_input_n_o(flt_n), .cmp_o(cmp), .level_o(lvl));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      err_count++;
    end
  endtask

  // Holds the request until ack or err is sampled high at a rising edge
  task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    rd = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1 && err !== 1'b1)
    begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic wc(input logic [31:0] d);
    bus(1'b1, pas_pkg::ADDR_CTRL, d);
  endtask

  task automatic rc();
    bus(1'b0, pas_pkg::ADDR_CTRL, 32'h0000_0000);
  endtask

  task automatic flt(input logic f, input logic c);
    @(posedge clk);
    freq <= f;
    creq <= c;
    #1;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic per();
    @(posedge clk);
    pst <= 1'b1;
    @(posedge clk);
    pst <= 1'b0;
    wt(1);
  endtask

  task automatic pins(input logic [3:0] eo, input logic [3:0] el);
    chk("oe", {28'h0, eo}, {28'h0, oe});
    chk("level", {28'h0, el}, {28'h0, lvl});
  endtask

  initial
  begin
    rows = '{'{9'h009, 2'h1, 4'hf, 4'h5, 1'h1}, '{9'h022, 2'h2, 4'hf, 4'ha, 1'h1},
             '{9'h033, 2'h1, 4'ha, 4'ha, 1'h1}, '{9'h06b, 2'h2, 4'h5, 4'h5, 1'h1},
             '{9'h009, 2'h2, 4'hf, 4'h6, 1'h0}, '{9'h022, 2'h1, 4'hf, 4'h6, 1'h0},
             '{9'h00c, 2'h3, 4'hf, 4'h6, 1'h0}, '{9'h008, 2'h3, 4'hf, 4'h6, 1'h0}};
    {rst, cyc, stb, we, pst, freq, creq} = 7'h40;
    adr = 6'h00;
    wdat = 32'h0000_0000;
    raw = 4'h6;
    err_count = 0;
    n_tests = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rc();
    chk("ctrl reset", 32'h0000_0000, rd);
    chk("irq reset", 32'h0000_0000, {31'h0, irq});
    bus(1'b0, 4'h6, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    bus(1'b1, pas_pkg::ADDR_PWM_DRIVE, 32'h0000_000f);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      wc({23'h0, rows[i].ctrl});
      flt(rows[i].fc[0], rows[i].fc[1]);
      pins(rows[i].oe, rows[i].lvl);
      wt(8);
      rc();
      chk("status", {31'h0, rows[i].st}, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
      flt(1'b0, 1'b0);
      wt(8);
      wc({23'h0, rows[i].ctrl});
      pins(rows[i].oe, rows[i].lvl);
      per();
      pins(4'hf, 4'h6);
    end
    $display("test table done");
    wc(32'h0000_0009);
    flt(1'b1, 1'b0);
    wt(8);
    wc(32'h0000_0009);
    rc();
    chk("status held", 32'h0000_0001, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    bus(1'b0, pas_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("fault level", 32'h0000_0001, rd);
    per();
    pins(4'hf, 4'h5);
    flt(1'b0, 1'b0);
    wt(8);
    rc();
    chk("no auto clear", 32'h0000_0001, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    wc(32'h0000_0009);
    per();
    pins(4'hf, 4'h6);
    $display("test persist done");
    bus(1'b1, pas_pkg::ADDR_IRQ_CLR, 32'h0000_0003);
    bus(1'b1, pas_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    wt(2);
    chk("irq idle", 32'h0000_0000, {31'h0, irq});
    wc(32'h0000_0089);
    wt(2);
    pins(4'hf, 4'h5);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    bus(1'b1, pas_pkg::ADDR_IRQ_EN, 32'h0000_0000);
    wt(2);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    bus(1'b1, pas_pkg::ADDR_IRQ_EN, 32'h0000_0001);
    wt(2);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    bus(1'b1, pas_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
    wt(2);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    wc(32'h0000_0009);
    wt(2);
    pins(4'hf, 4'h5);
    bus(1'b0, pas_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("waiting", 32'h0000_0002, rd);
    per();
    pins(4'hf, 4'h6);
    $display("test force done");
    wc(32'h0000_0189);
    wt(2);
    rc();
    chk("forced auto", 32'h0000_0000, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    pins(4'hf, 4'h5);
    per();
    pins(4'hf, 4'h6);
    wc(32'h0000_0189);
    rc();
    chk("forced auto on", 32'h0000_0000, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    pins(4'hf, 4'h5);
    per();
    pins(4'hf, 4'h6);
    wc(32'h0000_0109);
    flt(1'b1, 1'b0);
    wt(8);
    rc();
    chk("auto set", 32'h0000_0001, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    flt(1'b0, 1'b0);
    wt(8);
    rc();
    chk("auto clear", 32'h0000_0000, {31'h0, rd[pas_pkg::CTRL_ESTAT]});
    pins(4'hf, 4'h5);
    per();
    pins(4'hf, 4'h6);
    $display("test restart done");
    end_of_test();
  end
endmodule // pas_shutdown_test
